// >>> verilog/flash_sec_pkg.sv
// constants for the flash security option block
`default_nettype none
package flash_sec_pkg;
  localparam logic [15:0] ADDR_CLOCK_DIVIDER = 16'h1820;
  localparam logic [15:0] ADDR_OPTION_WORK   = 16'h1821;
  localparam logic [15:0] ADDR_CONFIG        = 16'h1823;
  localparam logic [15:0] ADDR_PROTECT_WORK  = 16'h1824;
  localparam logic [15:0] ADDR_CMD_STATUS    = 16'h1825;
  localparam logic [15:0] ADDR_CMD_CODE      = 16'h1826;
  localparam logic [15:0] ADDR_KEY_BASE      = 16'hFFB0;
  localparam logic [15:0] ADDR_NV_PROTECT    = 16'hFFBD;
  localparam logic [15:0] ADDR_NV_OPTIONS    = 16'hFFBF;
  localparam logic [15:0] ADDR_KEY_ENTRY     = 16'h1828;
  localparam logic [15:0] ADDR_SEC_STATUS    = 16'h1829;
  localparam int KEY_BYTES       = 8;
  localparam int OPT_KEY_ENABLE  = 7;
  localparam int OPT_REDIR_DIS   = 6;
  localparam int CFG_KEY_ACCESS  = 5;
  localparam int DIV_LOADED      = 7;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [7:0] CFG_MASK    = 8'h20;
  localparam logic [7:0] OPT_MASK    = 8'hC3;
  localparam logic [7:0] STATUS_MASK = 8'hF4;
endpackage
`default_nettype wire

// >>> verilog/key_compare.sv
// eight byte backdoor key comparator
`timescale 1ns/1ns
`default_nettype none
module key_compare (
  input  wire logic [63:0] stored_key,
  input  wire logic [63:0] entered_key,
  input  wire logic [7:0]  entered_valid,
  output logic             key_match
);
  logic [7:0] byte_ok;
  genvar g;
  generate
    for (g = 0; g < flash_sec_pkg::KEY_BYTES; g++) begin : g_byte
      // RL10: every byte equal
      assign byte_ok[g] = entered_valid[g] && (entered_key[8*g +: 8] == stored_key[8*g +: 8]);
    end
  endgenerate
  assign key_match = &byte_ok;
endmodule
`default_nettype wire

// >>> verilog/flash_security_options.sv
// flash protection, option copy and backdoor key security logic
// Summary of operation
// RL1: reset copies nonvolatile bytes into working registers
// RL2: key enable allows key to unlock
// RL3: key accepted only from secure code
// RL4: debug path key writes refused
// RL5: key enable zero disables key
// RL6: otherwise unlock only after blank erase
// RL7: security code 1:0 means unsecured
// RL8: stored eight byte key is reference
// RL9: software may use any array address
// RL10: all bytes match, unlock until reset
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module flash_security_options (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [7:0]  rdata,
  input  wire logic        from_secure_code,
  input  wire logic        from_debug,
  input  wire logic [7:0]  nv_protect_byte,
  input  wire logic [7:0]  nv_options_byte,
  input  wire logic [63:0] nv_key,
  input  wire logic        array_verified_blank,
  output logic             secured,
  output logic [7:0]       protection_out,
  output logic             vector_redirect_disable
);
  typedef enum logic [2:0] {
    ST_LOAD   = 3'b001,
    ST_SECURE = 3'b010,
    ST_OPEN   = 3'b100
  } sec_state_e;

  sec_state_e sec_state_r;
  sec_state_e sec_state_nxt;
  logic [7:0]  divider_r;
  logic [7:0]  option_r;
  logic [7:0]  config_r;
  logic [7:0]  protect_r;
  logic [7:0]  status_r;
  logic [7:0]  cmd_r;
  logic [63:0] entry_key_r;
  logic [7:0]  entry_valid_r;
  logic [2:0]  entry_idx_r;
  logic        key_match;
  logic        key_enable;
  logic        key_write_ok;
  logic [7:0]  rdata_nxt;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction

  // RL2: key enable bit
  assign key_enable = option_r[flash_sec_pkg::OPT_KEY_ENABLE];
  // RL3: secure code, key access set, not debug
  assign key_write_ok = wr_stb && hit(addr, flash_sec_pkg::ADDR_KEY_ENTRY) && from_secure_code
                        && !from_debug && config_r[flash_sec_pkg::CFG_KEY_ACCESS] && key_enable;

  // RL8: compare against stored key
  key_compare u_cmp (
    .stored_key    (nv_key),
    .entered_key   (entry_key_r),
    .entered_valid (entry_valid_r),
    .key_match     (key_match)
  );

  // RL1: working copies loaded after reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      option_r  <= flash_sec_pkg::RESET_BYTE;
      protect_r <= flash_sec_pkg::RESET_BYTE;
    end else if (sec_state_r == ST_LOAD) begin
      option_r  <= nv_options_byte & flash_sec_pkg::OPT_MASK;
      protect_r <= nv_protect_byte;
    end
  end

  // divider written once only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      divider_r <= flash_sec_pkg::RESET_BYTE;
    end else if (wr_stb && hit(addr, flash_sec_pkg::ADDR_CLOCK_DIVIDER) && !divider_r[flash_sec_pkg::DIV_LOADED]) begin
      divider_r <= {1'b1, wdata[6:0]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      config_r <= flash_sec_pkg::RESET_BYTE;
      cmd_r    <= flash_sec_pkg::RESET_BYTE;
      status_r <= flash_sec_pkg::RESET_BYTE;
    end else begin
      if (wr_stb && hit(addr, flash_sec_pkg::ADDR_CONFIG)) begin
        config_r <= wdata & flash_sec_pkg::CFG_MASK;
      end
      if (wr_stb && hit(addr, flash_sec_pkg::ADDR_CMD_CODE)) begin
        cmd_r <= wdata;
      end
      status_r <= {1'b1, 1'b1, 3'h0, array_verified_blank, 2'h0} & flash_sec_pkg::STATUS_MASK;
    end
  end

  // RL4: debug key bytes never stored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      entry_key_r   <= 64'h0;
      entry_valid_r <= 8'h00;
      entry_idx_r   <= 3'h0;
    end else if (key_write_ok && sec_state_r == ST_SECURE) begin
      entry_key_r[8*entry_idx_r +: 8] <= wdata;
      entry_valid_r[entry_idx_r]      <= 1'b1;
      entry_idx_r                     <= entry_idx_r + 3'h1;
    end
  end

  always_comb begin
    sec_state_nxt = sec_state_r;
    unique case (sec_state_r)
      ST_LOAD: begin
        // RL7: only 1:0 is unsecured
        if (nv_options_byte[1:0] == flash_sec_pkg::SEC_UNSECURED) begin
          sec_state_nxt = ST_OPEN;
        end else begin
          sec_state_nxt = ST_SECURE;
        end
      end
      ST_SECURE: begin
        // RL5: key ignored when disabled
        if (key_enable && key_match) begin
          // RL10: full match unlocks
          sec_state_nxt = ST_OPEN;
        // RL6: blank verified array unlocks
        end else if (array_verified_blank) begin
          sec_state_nxt = ST_OPEN;
        end
      end
      ST_OPEN: begin
        sec_state_nxt = ST_OPEN;
      end
      default: begin
        sec_state_nxt = ST_LOAD;
      end
    endcase
  end

  // RL10: open persists until reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sec_state_r <= ST_LOAD;
    end else begin
      sec_state_r <= sec_state_nxt;
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (hit(addr, flash_sec_pkg::ADDR_CLOCK_DIVIDER)) rdata_nxt = divider_r;
    if (hit(addr, flash_sec_pkg::ADDR_OPTION_WORK))   rdata_nxt = option_r;
    if (hit(addr, flash_sec_pkg::ADDR_CONFIG))        rdata_nxt = config_r;
    if (hit(addr, flash_sec_pkg::ADDR_PROTECT_WORK))  rdata_nxt = protect_r;
    if (hit(addr, flash_sec_pkg::ADDR_CMD_STATUS))    rdata_nxt = status_r;
    if (hit(addr, flash_sec_pkg::ADDR_CMD_CODE))      rdata_nxt = cmd_r;
    if (hit(addr, flash_sec_pkg::ADDR_SEC_STATUS))    rdata_nxt = {7'h0, sec_state_r != ST_OPEN};
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= 8'h00;
    end
  end

  assign secured                 = (sec_state_r != ST_OPEN);
  assign protection_out          = protect_r;
  assign vector_redirect_disable = option_r[flash_sec_pkg::OPT_REDIR_DIS];
endmodule
`default_nettype wire

// >>> test/nv_flash_model.sv
// nonvolatile flash contents seen by the security block
`timescale 1ns/1ns
`default_nettype none
module nv_flash_model #(
  parameter logic [63:0] KEY = 64'h0
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  prog_prot,
  input  wire logic [7:0]  prog_opt,
  input  wire logic        erase_req,
  output logic      [7:0]  nv_protect_byte,
  output logic      [7:0]  nv_options_byte,
  output logic      [63:0] nv_key,
  output logic             array_verified_blank
);
  assign nv_key = KEY;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nv_protect_byte <= prog_prot;
      nv_options_byte <= prog_opt;
    end
  end
  // erase request may name any array address
  always_ff @(posedge ref_clk) begin
    if (rst) array_verified_blank <= 1'b0;
    else if (erase_req) array_verified_blank <= 1'b1;
  end
endmodule
`default_nettype wire

// >>> test/flash_sec_properties.sv
// checker for the flash security option block
`timescale 1ns/1ns
`default_nettype none
module flash_sec_properties (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [15:0] addr,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [7:0]  rdata,
  input wire logic        from_secure_code,
  input wire logic        from_debug,
  input wire logic [7:0]  nv_protect_byte,
  input wire logic [7:0]  nv_options_byte,
  input wire logic        array_verified_blank,
  input wire logic        secured,
  input wire logic [7:0]  protection_out,
  input wire logic        vector_redirect_disable
);
  logic [1:0] age_r;
  wire logic  up = age_r == 2'h3;
  wire logic  gw = wr_stb && addr == flash_sec_pkg::ADDR_KEY_ENTRY && from_secure_code && !from_debug;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge ref_clk) begin
    if (rst) age_r <= 2'h0;
    else if (!up) age_r <= age_r + 2'h1;
  end
  sequence rel_s;
    $fell(rst);
  endsequence
  sequence opt_rd_s;
    rd_stb && addr == flash_sec_pkg::ADDR_OPTION_WORK;
  endsequence
  chk_prot_copy: assert property (rel_s |=> protection_out == nv_protect_byte)
    else $error("protection not loaded");
  chk_redir_copy: assert property (rel_s |=> vector_redirect_disable == nv_options_byte[6])
    else $error("redirect bit not loaded");
  chk_opt_read: assert property (opt_rd_s |=> rdata == (nv_options_byte & flash_sec_pkg::OPT_MASK))
    else $error("option read wrong");
  chk_sec_decode: assert property (rel_s ##1 !array_verified_blank |=> secured == (nv_options_byte[1:0] != 2'h2))
    else $error("security decode wrong");
  chk_key_source: assert property ($fell(secured) && up && !array_verified_blank |-> $past(gw) || $past(gw, 2) || $past(gw, 3))
    else $error("unlock without secure key write");
  chk_key_off: assert property (up && secured && !nv_options_byte[7] && !array_verified_blank |=> secured)
    else $error("unlock with key disabled");
  chk_blank_open: assert property (up && array_verified_blank |-> ##[0:3] !secured)
    else $error("blank array left secured");
  chk_open_holds: assert property (up && !secured |=> !secured)
    else $error("security re-engaged");
endmodule
bind flash_security_options flash_sec_properties chk (.*);
`default_nettype wire

// >>> test/tb_top.sv
// testbench for the flash security option block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [63:0] KEY = 64'h5A3C_96E1_0F7B_24D8;
  logic        ref_clk, rst, wr_stb, rd_stb, from_secure_code, from_debug, erase_req;
  logic        array_verified_blank, secured, vector_redirect_disable, rd_q, sec;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, prog_prot, prog_opt, nv_protect_byte, nv_options_byte, protection_out;
  logic [63:0] nv_key;
  logic [15:0] q[$];
  logic [31:0] x;
  int          err_count, tests_run;
  flash_security_options DUT (.*);
  nv_flash_model #(.KEY(KEY)) nvm (.*);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    wr_stb <= w;
    rd_stb <= r;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
    q.push_back({m, e});
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  always @(posedge ref_clk) begin
    if (rd_q) begin
      tests_run++;
      if ((rdata & q[0][15:8]) !== (q[0][7:0] & q[0][15:8])) begin
        err_count++;
        $display("BAD %0t read %h", $time, rdata);
      end
      void'(q.pop_front());
    end
    rd_q <= rd_stb;
  end
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    err_count++;
    results;
  end
  initial begin
    err_count = 0;
    tests_run = 0;
    x = 32'hD;
    for (int c = 0; c < 6; c++) begin
      x = xs(x);
      rst <= 1'b1;
      erase_req <= 1'b0;
      from_secure_code <= 1'b0;
      from_debug <= 1'b0;
      prog_prot <= x[7:0];
      prog_opt <= {c < 4, x[14], 4'h0, x[9:8]};
      repeat (c == 0 ? 20 : 2) bus(1'b0, 1'b0, 16'h0000, 8'h00);
      rst <= 1'b0;
      repeat (2) bus(1'b0, 1'b0, 16'h0000, 8'h00);
      rd(flash_sec_pkg::ADDR_OPTION_WORK, prog_opt & flash_sec_pkg::OPT_MASK, 8'hFF);
      rd(flash_sec_pkg::ADDR_PROTECT_WORK, prog_prot, 8'hFF);
      rd(16'h1822, 8'h00, 8'hFF);
      bus(1'b1, 1'b0, flash_sec_pkg::ADDR_CONFIG, 8'h20);
      from_secure_code <= c != 1;
      from_debug <= c == 2;
      erase_req <= c == 5;
      for (int i = 0; i < 8; i++) begin
        bus(1'b1, 1'b0, flash_sec_pkg::ADDR_KEY_ENTRY, KEY[i*8 +: 8] ^ {7'h0, c == 3 && i == 7});
      end
      repeat (3) bus(1'b0, 1'b0, 16'h0000, 8'h00);
      sec = x[9:8] != 2'h2 && c != 0 && c != 5;
      rd(flash_sec_pkg::ADDR_SEC_STATUS, {7'h0, sec}, 8'h01);
      repeat (2) bus(1'b0, 1'b0, 16'h0000, 8'h00);
      $display("case %0d done", c);
    end
    results;
  end
endmodule
`default_nettype wire
